// ===== src/vic_top.sv
// Vectored external interrupt controller with AXI4-Lite registers
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module vic_top
    import vic_pkg::*;
#(
    parameter int PC_LINES = 12 // pin_change_inputs count
) (
    input  wire logic                    I_MCLK,        // 25 MHz clock
    input  wire logic                    I_RST_B,       // Async reset, active low
    input  wire logic                    I_EXT_IRQ_PIN, // ext_irq_pin pad level
    input  wire logic [PC_LINES-1:0]     I_PC_INPUTS,   // pin_change_inputs pad levels
    input  wire logic [PERIPH_COUNT-1:0] I_PERIPH_REQ,  // Internal requests, vectors 5..17
    input  wire logic                    I_IRQ_ACK,     // Core executes presented vector
    output logic                         O_IRQ_REQ,     // Request to core
    output logic      [VEC_W-1:0]        O_IRQ_VECTOR,  // Vector address to fetch
    output logic                         O_WAKE,        // Asynchronous wake request
    input  wire logic [7:0]              S_AXI_AWADDR,
    input  wire logic                    S_AXI_AWVALID,
    output logic                         S_AXI_AWREADY,
    input  wire logic [31:0]             S_AXI_WDATA,
    input  wire logic [3:0]              S_AXI_WSTRB,
    input  wire logic                    S_AXI_WVALID,
    output logic                         S_AXI_WREADY,
    output logic      [1:0]              S_AXI_BRESP,
    output logic                         S_AXI_BVALID,
    input  wire logic                    S_AXI_BREADY,
    input  wire logic [7:0]              S_AXI_ARADDR,
    input  wire logic                    S_AXI_ARVALID,
    output logic                         S_AXI_ARREADY,
    output logic      [31:0]             S_AXI_RDATA,
    output logic      [1:0]              S_AXI_RRESP,
    output logic                         S_AXI_RVALID,
    input  wire logic                    S_AXI_RREADY
);
    // ------------------------------------------------------------
    // Reset and pin synchronisers
    // ------------------------------------------------------------
    logic                rst_b;  // Synchronously released reset
    logic [PC_LINES:0]   pins_s; // Synced {ext pin, pin-change lines}
    logic                ext_s;  // Synced external pin
    logic [PC_LINES-1:0] pc_s;   // Synced pin-change lines

    vic_sync2 #(.W(1), .RST_VAL(1'b0)) u_rst_sync (
        .i_clk   (I_MCLK),
        .i_rst_b (I_RST_B),
        .i_d     (1'b1),
        .o_q     (rst_b)
    );

    // Pads are read whatever their direction, so driven outputs still fire
    vic_sync2 #(.W(PC_LINES+1), .RST_VAL('1)) u_pin_sync (
        .i_clk   (I_MCLK),
        .i_rst_b (I_RST_B),
        .i_d     ({I_EXT_IRQ_PIN, I_PC_INPUTS}),
        .o_q     (pins_s)
    );
    assign ext_s = pins_s[PC_LINES];
    assign pc_s  = pins_s[PC_LINES-1:0];

    // ------------------------------------------------------------
    // Register and detector state
    // ------------------------------------------------------------
    logic [1:0]          sense, next_sense;         // mcu_control_reg sense field
    logic [3:0]          enable, next_enable;       // Global and source enables
    logic [2:0]          flags, next_flags;         // Pending flags
    logic [7:0]          mask_lo, next_mask_lo;     // pin_change_mask_low
    logic [3:0]          mask_hi, next_mask_hi;     // pin_change_mask_high
    logic                ext_prev, next_ext_prev;   // Last synced ext pin
    logic [PC_LINES-1:0] pc_prev, next_pc_prev;     // Last synced pin-change lines
    logic                req, next_req;             // Registered request
    logic [VEC_W-1:0]    vec, next_vec;             // Registered vector address
    logic                wr_fire;                   // Register write this cycle
    logic [7:0]          wr_addr;                   // Held write address
    logic [31:0]         wr_data;                   // Held write data
    logic [3:0]          wr_strb;                   // Held write strobes
    logic                ext_edge;                  // Edge event per sense mode
    logic                ext_level;                 // Level request active
    logic                pc_set_lo, pc_set_hi;      // Group change events
    logic [2:0]          flag_set, flag_clr;        // Hardware set, clear terms
    logic                gie;                       // Global enable

    assign gie = enable[BIT_EN_GLOBAL];

    // ------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------
    always_comb begin
        // Edges need the clock; only valid while it runs
        unique case (sense)
            SENSE_ANY:     ext_edge = ext_s ^ ext_prev;
            SENSE_FALLING: ext_edge = ext_prev & ~ext_s;
            SENSE_RISING:  ext_edge = ~ext_prev & ext_s;
            default:       ext_edge = 1'b0;
        endcase
        // Level request follows the pin; no memory, so a vanished level leaves nothing
        ext_level = (sense == SENSE_LOW) & ~ext_s;
        // Masked toggles per group
        pc_set_lo = |((pc_s[7:0] ^ pc_prev[7:0]) & mask_lo);
        pc_set_hi = |((pc_s[PC_LINES-1:8] ^ pc_prev[PC_LINES-1:8]) & mask_hi);
    end

    // Wake path runs from the pads without the clock
    assign O_WAKE = (enable[BIT_EN_EXT] & (sense == SENSE_LOW) & ~I_EXT_IRQ_PIN)
                  | (enable[BIT_EN_PC_LOW] & |((I_PC_INPUTS[7:0] ^ pc_prev[7:0]) & mask_lo))
                  | (enable[BIT_EN_PC_HI]
                     & |((I_PC_INPUTS[PC_LINES-1:8] ^ pc_prev[PC_LINES-1:8]) & mask_hi));

    // ------------------------------------------------------------
    // Registers, flags and grant: next values
    // ------------------------------------------------------------
    always_comb begin
        logic [VEC_W-1:0] pick;
        logic             found;
        pick          = VEC_RESET_ADDR;
        found         = 1'b0;
        next_sense    = sense;
        next_enable   = enable;
        next_mask_lo  = mask_lo;
        next_mask_hi  = mask_hi;
        next_ext_prev = ext_s;
        next_pc_prev  = pc_s;
        flag_set      = {pc_set_hi, pc_set_lo, ext_edge};
        flag_clr      = 3'h0;
        // Vector taken by the core clears its flag
        if (I_IRQ_ACK && req) begin
            flag_clr[BIT_FL_EXT]    = (vec == VEC_EXT_ADDR);
            flag_clr[BIT_FL_PC_LOW] = (vec == VEC_PC_LOW_ADDR);
            flag_clr[BIT_FL_PC_HI]  = (vec == VEC_PC_HIGH_ADDR);
        end
        // Software writes, low byte only
        if (wr_fire && wr_strb[0]) begin
            unique case (wr_addr)
                OFS_CONTROL:   next_sense   = wr_data[1:0];
                OFS_ENABLE:    next_enable  = wr_data[3:0];
                OFS_FLAGS:     flag_clr     = flag_clr | wr_data[2:0];
                OFS_MASK_LOW:  next_mask_lo = wr_data[7:0];
                OFS_MASK_HIGH: next_mask_hi = wr_data[3:0];
                default:       ;
            endcase
        end
        // Set wins over clear
        next_flags = (flags & ~flag_clr) | flag_set;
        // Level mode keeps the external flag at zero
        if (next_sense == SENSE_LOW) begin
            next_flags[BIT_FL_EXT] = 1'b0;
        end
        // Internal sources, lowest index first
        for (int i = 0; i < PERIPH_COUNT; i++) begin
            if (!found && I_PERIPH_REQ[i]) begin
                found = 1'b1;
                pick  = VEC_PERIPH_BASE + VEC_W'(i);
            end
        end
        // Pin sources outrank internal ones, lowest vector wins
        if (enable[BIT_EN_PC_HI] && flags[BIT_FL_PC_HI]) begin
            found = 1'b1;
            pick  = VEC_PC_HIGH_ADDR;
        end
        if (enable[BIT_EN_PC_LOW] && flags[BIT_FL_PC_LOW]) begin
            found = 1'b1;
            pick  = VEC_PC_LOW_ADDR;
        end
        if (enable[BIT_EN_EXT] && (flags[BIT_FL_EXT] || ext_level)) begin
            found = 1'b1;
            pick  = VEC_EXT_ADDR;
        end
        // Global gate; idle shows the reset vector
        next_req = gie & found;
        next_vec = next_req ? pick : VEC_RESET_ADDR;
    end

    // Registers only
    always_ff @(posedge I_MCLK or negedge rst_b) begin
        if (!rst_b) begin
            sense    <= RST_SENSE;
            enable   <= RST_ENABLE;
            flags    <= RST_FLAGS;
            mask_lo  <= RST_MASK_L;
            mask_hi  <= RST_MASK_H;
            ext_prev <= 1'b1;
            pc_prev  <= '1;
            req      <= 1'b0;
            vec      <= VEC_RESET_ADDR;
        end else begin
            sense    <= next_sense;
            enable   <= next_enable;
            flags    <= next_flags;
            mask_lo  <= next_mask_lo;
            mask_hi  <= next_mask_hi;
            ext_prev <= next_ext_prev;
            pc_prev  <= next_pc_prev;
            req      <= next_req;
            vec      <= next_vec;
        end
    end

    assign O_IRQ_REQ    = req;
    assign O_IRQ_VECTOR = vec;

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    logic aw_held, next_aw_held; // Address taken
    logic w_held, next_w_held;   // Data taken
    logic bvalid, next_bvalid;   // Response pending
    logic [1:0] bresp, next_bresp;
    logic [7:0]  next_wr_addr;
    logic [31:0] next_wr_data;
    logic [3:0]  next_wr_strb;

    assign S_AXI_AWREADY = ~aw_held & ~bvalid;
    assign S_AXI_WREADY  = ~w_held & ~bvalid;
    assign wr_fire       = aw_held & w_held & ~bvalid;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        next_wr_strb = wr_strb;
        // Address and data in either order
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            next_aw_held = 1'b1;
            next_wr_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            next_w_held  = 1'b1;
            next_wr_data = S_AXI_WDATA;
            next_wr_strb = S_AXI_WSTRB;
        end
        // Both held: write and answer
        if (wr_fire) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = (wr_addr <= OFS_STATUS && wr_addr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid && S_AXI_BREADY) begin
            next_bvalid = 1'b0;
        end
    end

    always_ff @(posedge I_MCLK or negedge rst_b) begin
        if (!rst_b) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
            wr_addr <= 8'h00;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
        end else begin
            aw_held <= next_aw_held;
            w_held  <= next_w_held;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
            wr_strb <= next_wr_strb;
        end
    end

    assign S_AXI_BVALID = bvalid;
    assign S_AXI_BRESP  = bresp;

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    logic        rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0]  rresp, next_rresp;

    assign S_AXI_ARREADY = ~rvalid;

    always_comb begin
        next_rvalid = rvalid;
        next_rdata  = rdata;
        next_rresp  = rresp;
        if (S_AXI_ARVALID && !rvalid) begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            unique case (S_AXI_ARADDR)
                OFS_CONTROL:   next_rdata = {30'h0, sense};
                OFS_ENABLE:    next_rdata = {28'h0, enable};
                OFS_FLAGS:     next_rdata = {29'h0, flags};
                OFS_MASK_LOW:  next_rdata = {24'h0, mask_lo};
                OFS_MASK_HIGH: next_rdata = {28'h0, mask_hi};
                OFS_STATUS:    next_rdata = {1'b0, req, vec[4:0], ext_s, 12'h0, pc_s};
                default: begin
                    next_rdata = 32'h00000000;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end else if (rvalid && S_AXI_RREADY) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge I_MCLK or negedge rst_b) begin
        if (!rst_b) begin
            rvalid <= 1'b0;
            rdata  <= 32'h00000000;
            rresp  <= RESP_OKAY;
        end else begin
            rvalid <= next_rvalid;
            rdata  <= next_rdata;
            rresp  <= next_rresp;
        end
    end

    assign S_AXI_RVALID = rvalid;
    assign S_AXI_RDATA  = rdata;
    assign S_AXI_RRESP  = rresp;

    // ------------------------------------------------------------
    // Assertions and covers
    // ------------------------------------------------------------
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!rst_b);

    a_idle_reset_vec: assert property (!O_IRQ_REQ |-> O_IRQ_VECTOR == VEC_RESET_ADDR)
        else $error("idle vector not zero");
    a_ext_grant_first: assert property (gie && enable[BIT_EN_EXT] && flags[BIT_FL_EXT]
        |=> O_IRQ_REQ && O_IRQ_VECTOR == VEC_EXT_ADDR) else $error("external not granted first");
    a_periph_vector: assert property (gie && I_PERIPH_REQ == 13'h0004 && enable[3:1] == 3'h0
        |=> O_IRQ_VECTOR == VEC_TIMER16_FIRST + 16'h0001) else $error("timer16 compare A address wrong");
    a_timer8_vector: assert property (gie && I_PERIPH_REQ == 13'h0020 && enable[3:1] == 3'h0
        |=> O_IRQ_VECTOR == VEC_TIMER8_FIRST) else $error("timer8 address wrong");
    a_last_vector: assert property (gie && I_PERIPH_REQ == 13'h1000 && enable[3:1] == 3'h0
        |=> O_IRQ_VECTOR == VEC_LAST_ADDR) else $error("last vector address wrong");
    a_pc_low_set: assert property (pc_set_lo |=> flags[BIT_FL_PC_LOW])
        else $error("low group toggle lost");
    a_pc_high_set: assert property (pc_set_hi |=> flags[BIT_FL_PC_HI])
        else $error("high group toggle lost");
    a_mask_gate: assert property (mask_lo == 8'h00 && !flags[BIT_FL_PC_LOW] |=> !flags[BIT_FL_PC_LOW])
        else $error("masked pin set low flag");
    a_level_hold: assert property (gie && enable[BIT_EN_EXT] && ext_level [*2]
        |=> O_IRQ_REQ && O_IRQ_VECTOR == VEC_EXT_ADDR) else $error("low level not requested");
    a_level_flag: assert property (sense == SENSE_LOW |-> !flags[BIT_FL_EXT])
        else $error("flag set in level mode");
    a_ack_clear: assert property (I_IRQ_ACK && req && vec == VEC_PC_LOW_ADDR && !pc_set_lo
        |=> !flags[BIT_FL_PC_LOW]) else $error("flag kept after vector");
    a_global_gate: assert property (!gie |=> !O_IRQ_REQ)
        else $error("request without global enable");
    a_falling_edge: assert property (sense == SENSE_FALLING && $fell(ext_s) && $stable(sense)
        |=> flags[BIT_FL_EXT]) else $error("falling edge missed");

    c_ext_level: cover property (gie && ext_level ##1 O_IRQ_REQ);
    c_pc_ack: cover property (flags[BIT_FL_PC_HI] ##[1:4] (I_IRQ_ACK && vec == VEC_PC_HIGH_ADDR));
    c_axi_write: cover property (wr_fire ##1 S_AXI_BVALID);

endmodule : vic_top
`default_nettype wire

// ===== pkg/vic_pkg.sv
// Constants shared by the vectored external interrupt controller
package vic_pkg;

    // ------------------------------------------------------------
    // Vector table
    // ------------------------------------------------------------
    localparam int          VECTOR_COUNT      = 17;      // Entries in the table
    localparam int          VEC_W             = 16;      // Program address width
    localparam int          PERIPH_COUNT      = 13;      // Internal sources, vectors 5..17
    localparam logic [15:0] VEC_RESET_ADDR    = 16'h0000; // All reset causes
    localparam logic [15:0] VEC_EXT_ADDR      = 16'h0001; // External pin request
    localparam logic [15:0] VEC_PC_LOW_ADDR   = 16'h0002; // Pin-change group low
    localparam logic [15:0] VEC_PC_HIGH_ADDR  = 16'h0003; // Pin-change group high
    localparam logic [15:0] VEC_PERIPH_BASE   = 16'h0004; // Watchdog timeout, first internal
    localparam logic [15:0] VEC_TIMER16_FIRST = 16'h0005; // Capture, then compare A/B, overflow
    localparam logic [15:0] VEC_TIMER8_FIRST  = 16'h0009; // Compare A/B, then overflow
    localparam logic [15:0] VEC_LAST_ADDR     = 16'h0010; // Serial overflow, last entry

    // ------------------------------------------------------------
    // Sense select encodings
    // ------------------------------------------------------------
    localparam logic [1:0] SENSE_LOW     = 2'h0; // Low level
    localparam logic [1:0] SENSE_ANY     = 2'h1; // Any change
    localparam logic [1:0] SENSE_FALLING = 2'h2; // Falling edge
    localparam logic [1:0] SENSE_RISING  = 2'h3; // Rising edge

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL   = 8'h00; // mcu_control_reg sense bits
    localparam logic [7:0] OFS_ENABLE    = 8'h04; // Global and source enables
    localparam logic [7:0] OFS_FLAGS     = 8'h08; // Pending flags, write one to clear
    localparam logic [7:0] OFS_MASK_LOW  = 8'h0C; // pin_change_mask_low
    localparam logic [7:0] OFS_MASK_HIGH = 8'h10; // pin_change_mask_high
    localparam logic [7:0] OFS_STATUS    = 8'h14; // Request, vector, pin levels

    // Field positions
    localparam int BIT_EN_GLOBAL = 0; // Global interrupt enable
    localparam int BIT_EN_EXT    = 1; // External pin enable
    localparam int BIT_EN_PC_LOW = 2; // Low group enable
    localparam int BIT_EN_PC_HI  = 3; // High group enable
    localparam int BIT_FL_EXT    = 0; // ext_irq_flag
    localparam int BIT_FL_PC_LOW = 1; // pin_change_irq_low flag
    localparam int BIT_FL_PC_HI  = 2; // pin_change_irq_high flag

    // Reset values
    localparam logic [1:0] RST_SENSE  = 2'h0;
    localparam logic [3:0] RST_ENABLE = 4'h0;
    localparam logic [2:0] RST_FLAGS  = 3'h0;
    localparam logic [7:0] RST_MASK_L = 8'h00;
    localparam logic [3:0] RST_MASK_H = 4'h0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : vic_pkg

// ===== src/vic_sync2.sv
// Two flip-flop synchroniser, parameterised width
`timescale 1ns/1ps
`default_nettype none
module vic_sync2 #(
    parameter int          W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         i_clk,   // Destination clock
    input  wire logic         i_rst_b, // Async reset, active low
    input  wire logic [W-1:0] i_d,     // Asynchronous input
    output logic      [W-1:0] o_q      // Synchronised output
);
    logic [W-1:0] meta; // First stage, read only by second stage

    // ------------------------------------------------------------
    // Two stages
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta <= RST_VAL;
            o_q  <= RST_VAL;
        end else begin
            meta <= i_d;
            o_q  <= meta;
        end
    end
endmodule : vic_sync2
`default_nettype wire

// ===== tb/vic_core_model.sv
// Processor core model that executes presented vectors
`timescale 1ns/1ps
`default_nettype none
module vic_core_model #(
    parameter int DLY = 2 // Cycles from request to execution
) (
    input  wire logic i_clk, // Core clock
    input  wire logic i_en,  // Servicing allowed
    input  wire logic i_req, // Request from controller
    output var  logic o_ack  // One-cycle execute pulse
);
    // Takes a request, waits, executes one vector, then backs off
    initial o_ack = 1'b0;
    always begin
        @(posedge i_clk);
        if (i_en && i_req === 1'b1) begin
            repeat (DLY) @(posedge i_clk);
            o_ack <= i_req;
            @(posedge i_clk);
            o_ack <= 1'b0;
            repeat (3) @(posedge i_clk);
        end
    end
endmodule : vic_core_model
`default_nettype wire

// ===== tb/vic_top_tb_top.sv
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
module vic_top_tb_top;
    import vic_pkg::*;
    localparam logic [11:0] CODES = 12'h5FA; // Sense code per edge step
    localparam logic [5:0]  FIRES = 6'h39;   // Whether each step requests
    logic        mclk = 1'b0, rst_b = 1'b0, ext = 1'b1, core_en = 1'b1, ack, req, wake;
    logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0, awrdy, wrdy, bv, ardy, rv;
    logic [11:0] pc = 12'hFFF;
    logic [12:0] preq = 13'h0000;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd_v;
    logic [15:0] vec;
    logic [1:0]  bresp, rresp, resp;
    int          errors = 0, checks = 0, cyc = 0;
    always #20 mclk = ~mclk;
    vic_top uut (.I_MCLK(mclk), .I_RST_B(rst_b), .I_EXT_IRQ_PIN(ext), .I_PC_INPUTS(pc), .I_PERIPH_REQ(preq),
        .I_IRQ_ACK(ack), .O_IRQ_REQ(req), .O_IRQ_VECTOR(vec), .O_WAKE(wake), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(ardy), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry));
    vic_core_model #(.DLY(2)) core (.i_clk(mclk), .i_en(core_en), .i_req(req), .o_ack(ack));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task results;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results
    // Write: both channels offered, each dropped when taken
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        awaddr <= a; wdata <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
        forever begin
            @(negedge mclk); ta = awrdy; tw = wrdy; tb = bv; resp = bresp;
            @(posedge mclk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            if (tb) break;
        end
    endtask : wr
    task rd(input logic [7:0] a);
        logic ta, tb;
        araddr <= a; arv <= 1'b1; rry <= 1'b1;
        forever begin
            @(negedge mclk); ta = ardy; tb = rv; rd_v = rdata; resp = rresp;
            @(posedge mclk);
            if (ta) arv <= 1'b0;
            if (tb) break;
        end
    endtask : rd
    // Waits for a request and compares the vector
    task see(input logic [15:0] v);
        int n;
        for (n = 0; n < 20 && req !== 1'b1; n++) @(negedge mclk);
        chk(32'(vec), 32'(v));
        @(posedge mclk);
    endtask : see
    task idle;
        repeat (10) @(negedge mclk);
        chk(32'(req), 32'h0);
        @(posedge mclk);
    endtask : idle
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        chk(32'(vec), 32'h0);
        rd(OFS_CONTROL); chk(rd_v, 32'h0);
        rd(8'h18); chk(32'(resp), 32'(RESP_SLVERR));
        wr(8'h1C, 32'h1); chk(32'(resp), 32'(RESP_SLVERR));
    endtask : t_reset
    task t_table;
        int i;
        wr(OFS_ENABLE, 32'h1);
        for (i = 0; i < 13; i++) begin
            preq <= 13'h1 << i; see(16'(i + 4));
            preq <= 13'h0; repeat (3) @(posedge mclk);
        end
        preq <= 13'h1FFF; see(16'h4);
        wr(OFS_ENABLE, 32'h0); idle();
        preq <= 13'h0;
    endtask : t_table
    task t_pins;
        wr(OFS_CONTROL, 32'h1); wr(OFS_MASK_LOW, 32'h1); wr(OFS_MASK_HIGH, 32'h1); wr(OFS_ENABLE, 32'hD);
        pc[1] <= ~pc[1]; idle();
        pc[0] <= ~pc[0]; see(16'h2);
        idle();
        rd(OFS_FLAGS); chk(rd_v, 32'h0);
        pc[8] <= ~pc[8]; see(16'h3);
        idle();
    endtask : t_pins
    task t_ext;
        int k;
        core_en <= 1'b0; wr(OFS_ENABLE, 32'h3);
        for (k = 0; k < 6; k++) begin
            wr(OFS_CONTROL, 32'(CODES[2*k +: 2])); ext <= (k % 2 == 1); repeat (8) @(negedge mclk);
            chk(32'(req), 32'(FIRES[k]));
            @(posedge mclk);
            wr(OFS_FLAGS, 32'h1); idle();
        end
        wr(OFS_CONTROL, 32'h0); ext <= 1'b0; see(16'h1);
        chk(32'(wake), 32'h1);
        rd(OFS_FLAGS); chk(rd_v, 32'h0);
        ext <= 1'b1; idle();
    endtask : t_ext
    initial begin
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        t_reset(); t_table(); t_pins(); t_ext();
        results();
    end
    // Cuts a hang short
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin errors++; results(); end
    end
endmodule : vic_top_tb_top
`default_nettype wire
